/* logic/psram_host.v */
// Host-side controller for an asynchronous pseudo-static memory: power-up,
// power-down, reads with page access, writes and standby settling.
// Assumes the memory pins are wired straight out; the memory has no clock,
// so every pin duration is timed here in cycles of clk.
//
// How it works
// RULE_01 - Power-down holds power_keep_enable low at least 80 or 90 ns by grade.
// RULE_02 - After power-down exit, chip select stays high 350 us before any access.
// RULE_03 - Sequence one holds power_keep_enable low 50 us after supply is good.
// RULE_04 - Sequence one keeps chip select high 350 us after power_keep_enable rises.
// RULE_05 - Sequence two holds power_keep_enable high 50 us, then one power-down cycle.
// RULE_06 - Sequence two has chip select high before power_keep_enable rises.
// RULE_07 - The ordinary power-down entry and exit serves sequence two.
// RULE_08 - Sequence three needs both enables high with supply for 400 us.
// RULE_09 - Write strobe stays stable 10 ns after chip select rises for standby.
// RULE_10 - Memory delays standby by a read cycle if settling is violated.
// RULE_11 - Reads keep power_keep_enable high and the write strobe high.
// RULE_12 - With chip select and output strobe low, at least one lane is selected.
// RULE_13 - Writes keep power_keep_enable high.
// RULE_14 - Chip select may be tied low; output strobe alone then gates outputs.
// RULE_15 - Page reads change only the three lowest address bits.
`include "psram_host_defs.vh"

module psram_host #(
  parameter PU_SEQ = `PU_SEQ_LOW_FIRST,
  parameter FAST_GRADE = 0,
  parameter CS_TIED_LOW = 0,
  parameter RD_CYC = 8,
  parameter PAGE_CYC = 3,
  parameter PAGE_HOLD_CYC = 8,
  parameter C2LH_CYC = `CYC_US(`T_C2LH_US),
  parameter C2HL_CYC = `CYC_US(`T_C2HL_US),
  parameter CHHP_CYC = `CYC_US(`T_CHHP_US),
  parameter CHH_CYC = `CYC_US(`T_CHH_US)
) (
  // Clock and reset
  input wire clk,
  input wire reset,
  // User request port
  input wire req,
  input wire req_write,
  input wire [`ADDR_W-1:0] req_addr,
  input wire [`DATA_W-1:0] req_wdata,
  input wire [1:0] req_lanes,
  input wire pd_req,
  output reg ready,
  output reg [`DATA_W-1:0] rdata,
  output reg rdata_valid,
  output reg init_done,
  output reg powered_down,
  // Memory pins
  output reg chip_select_n,
  output reg power_keep_enable,
  output reg write_strobe_n,
  output reg output_strobe_n,
  output reg lower_lane_select_n,
  output reg upper_lane_select_n,
  output reg [`ADDR_W-1:0] mem_addr,
  input wire [`DATA_W-1:0] dq_in,
  output reg [`DATA_W-1:0] dq_out,
  output reg dq_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // States and derived cycle counts
  localparam [3:0] S_PU_LOW = 4'h0;
  localparam [3:0] S_PU_HIGH = 4'h1;
  localparam [3:0] S_CHH = 4'h2;
  localparam [3:0] S_IDLE = 4'h3;
  localparam [3:0] S_RD = 4'h4;
  localparam [3:0] S_RD_OPEN = 4'h5;
  localparam [3:0] S_WR = 4'h6;
  localparam [3:0] S_REC = 4'h7;
  localparam [3:0] S_PD_SETUP = 4'h8;
  localparam [3:0] S_PD_HOLD = 4'h9;

  localparam C2LP_CYC = FAST_GRADE ? `CYC_NS(`T_C2LP_FAST_NS) : `CYC_NS(`T_C2LP_SLOW_NS);
  localparam WC_CYC = FAST_GRADE ? `CYC_NS(`T_WC_FAST_NS) : `CYC_NS(`T_WC_SLOW_NS);
  localparam WP_CYC = FAST_GRADE ? `CYC_NS(`T_CW_FAST_NS) : `CYC_NS(`T_CW_SLOW_NS);
  localparam CHX_CYC = `CYC_NS(`T_CHX_NS);
  localparam CSP_CYC = `CYC_NS(`T_CSP_NS);
  // Recovery covers both the rest of the write cycle and standby settling
  localparam REC_CYC = (WC_CYC - WP_CYC) > CHX_CYC ? (WC_CYC - WP_CYC) : CHX_CYC;
  // Chip select level while the memory is selected
  localparam CS_ACTIVE = 1'b0;
  // Chip select level while no access runs; low when tied for strobe control
  localparam CS_REST = CS_TIED_LOW ? 1'b0 : 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // State, counter and the latched request held over a page close
  reg [3:0] state_r;
  reg [31:0] cnt_r;
  reg auto_pd_r;
  reg pend_r;
  reg pend_write_r;
  reg [`ADDR_W-1:0] pend_addr_r;
  reg [`DATA_W-1:0] pend_wdata_r;
  reg [1:0] pend_lanes_r;

  wire cnt_done = (cnt_r == 32'h0);

  // Request to start: the latched one wins over a fresh one
  wire s_write = pend_r ? pend_write_r : req_write;
  wire [`ADDR_W-1:0] s_addr = pend_r ? pend_addr_r : req_addr;
  wire [`DATA_W-1:0] s_wdata = pend_r ? pend_wdata_r : req_wdata;
  wire [1:0] s_lanes_in = pend_r ? pend_lanes_r : req_lanes;
  // An empty lane mask would leave both lanes off while reading
  wire [1:0] s_lanes = (s_lanes_in == `LANES_NONE) ? `LANES_BOTH : s_lanes_in; // RULE_12
  wire [1:0] p_lanes = (req_lanes == `LANES_NONE) ? `LANES_BOTH : req_lanes; // RULE_12

  // A page hit keeps every address bit above the page field
  wire page_hit = req && !req_write && !pd_req &&
    (req_addr[`ADDR_W-1:`PAGE_BITS] == mem_addr[`ADDR_W-1:`PAGE_BITS]); // RULE_15

  ////////////////////////////////////////////////////////////////////////////
  // Main sequencer; every pin and user output is a flip-flop
  always @(posedge clk) begin
    if (reset) begin
      rdata_valid <= 1'b0;
      rdata <= {`DATA_W{1'b0}};
      ready <= 1'b0;
      init_done <= 1'b0;
      powered_down <= 1'b0;
      chip_select_n <= 1'b1; // RULE_06
      write_strobe_n <= 1'b1;
      output_strobe_n <= 1'b1;
      lower_lane_select_n <= 1'b1;
      upper_lane_select_n <= 1'b1;
      mem_addr <= {`ADDR_W{1'b0}};
      dq_out <= {`DATA_W{1'b0}};
      dq_oe <= 1'b0;
      pend_r <= 1'b0;
      pend_write_r <= 1'b0;
      pend_addr_r <= {`ADDR_W{1'b0}};
      pend_wdata_r <= {`DATA_W{1'b0}};
      pend_lanes_r <= `LANES_NONE;
      // Reset stands in for the supply reaching its working level
      if (PU_SEQ == `PU_SEQ_LOW_FIRST) begin
        power_keep_enable <= 1'b0; // RULE_03
        state_r <= S_PU_LOW;
        cnt_r <= C2LH_CYC - 1;
        auto_pd_r <= 1'b0;
      end else if (PU_SEQ == `PU_SEQ_PD_CYCLE) begin
        power_keep_enable <= 1'b1; // RULE_06
        state_r <= S_PU_HIGH;
        cnt_r <= C2HL_CYC - 1; // RULE_05
        auto_pd_r <= 1'b1;
      end else begin
        // Both enables rise with supply only if the board holds them so
        power_keep_enable <= 1'b1; // RULE_08
        state_r <= S_PU_HIGH;
        cnt_r <= CHHP_CYC - 1; // RULE_08
        auto_pd_r <= 1'b0;
      end
    end else begin
      rdata_valid <= 1'b0;
      if (!cnt_done) begin
        cnt_r <= cnt_r - 32'h1;
      end
      case (state_r)
        S_PU_LOW: begin
          if (cnt_done) begin
            power_keep_enable <= 1'b1; // RULE_03
            state_r <= S_CHH;
            cnt_r <= CHH_CYC - 1; // RULE_04
          end
        end
        S_PU_HIGH: begin
          if (cnt_done) begin
            if (auto_pd_r) begin
              // The ordinary power-down path does the required cycle
              state_r <= S_PD_SETUP; // RULE_05 RULE_07
              cnt_r <= CSP_CYC - 1;
            end else begin
              chip_select_n <= CS_REST;
              state_r <= S_IDLE;
              ready <= 1'b1;
              init_done <= 1'b1; // RULE_08
            end
          end
        end
        S_CHH: begin
          // Chip select stays high for the whole wake wait
          if (cnt_done) begin
            chip_select_n <= CS_REST; // RULE_02 RULE_04
            state_r <= S_IDLE;
            ready <= 1'b1;
            init_done <= 1'b1;
          end
        end
        S_IDLE: begin
          if (pd_req) begin
            // Chip select goes high first and is held before the enable falls
            ready <= 1'b0;
            chip_select_n <= 1'b1;
            state_r <= S_PD_SETUP;
            cnt_r <= CSP_CYC - 1;
          end else if (req) begin
            ready <= 1'b0;
            mem_addr <= s_addr;
            chip_select_n <= CS_ACTIVE;
            lower_lane_select_n <= ~s_lanes[0];
            upper_lane_select_n <= ~s_lanes[1];
            if (s_write) begin
              write_strobe_n <= 1'b0; // RULE_13
              dq_out <= s_wdata;
              dq_oe <= 1'b1;
              state_r <= S_WR;
              cnt_r <= WP_CYC - 1;
            end else begin
              output_strobe_n <= 1'b0; // RULE_11 RULE_14
              state_r <= S_RD;
              cnt_r <= RD_CYC - 1;
            end
          end
        end
        S_RD: begin
          if (cnt_done) begin
            rdata <= dq_in;
            rdata_valid <= 1'b1;
            ready <= 1'b1;
            state_r <= S_RD_OPEN;
            cnt_r <= PAGE_HOLD_CYC - 1;
          end
        end
        S_RD_OPEN: begin
          if (page_hit) begin
            // Only the page field moves; the read stays open
            mem_addr[`PAGE_BITS-1:0] <= req_addr[`PAGE_BITS-1:0]; // RULE_15
            lower_lane_select_n <= ~p_lanes[0];
            upper_lane_select_n <= ~p_lanes[1];
            ready <= 1'b0;
            state_r <= S_RD;
            cnt_r <= PAGE_CYC - 1;
          end else if (req || pd_req || cnt_done) begin
            // Any other request is kept and started once standby settles
            if (req) begin
              pend_r <= 1'b1;
              pend_write_r <= req_write;
              pend_addr_r <= req_addr;
              pend_wdata_r <= req_wdata;
              pend_lanes_r <= req_lanes;
            end
            ready <= 1'b0;
            chip_select_n <= CS_REST;
            output_strobe_n <= 1'b1;
            state_r <= S_REC;
            cnt_r <= REC_CYC - 1;
          end
        end
        S_WR: begin
          if (cnt_done) begin
            // Data hold of zero lets the bus release on the strobe edge
            chip_select_n <= CS_REST;
            write_strobe_n <= 1'b1;
            dq_oe <= 1'b0;
            state_r <= S_REC;
            cnt_r <= REC_CYC - 1;
          end
        end
        S_REC: begin
          // Strobes stay high here so standby is not delayed by a read cycle
          if (cnt_done) begin // RULE_09 RULE_10
            lower_lane_select_n <= 1'b1;
            upper_lane_select_n <= 1'b1;
            if (pend_r) begin
              pend_r <= 1'b0;
              mem_addr <= s_addr;
              chip_select_n <= CS_ACTIVE;
              lower_lane_select_n <= ~s_lanes[0];
              upper_lane_select_n <= ~s_lanes[1];
              if (s_write) begin
                write_strobe_n <= 1'b0; // RULE_13
                dq_out <= s_wdata;
                dq_oe <= 1'b1;
                state_r <= S_WR;
                cnt_r <= WP_CYC - 1;
              end else begin
                output_strobe_n <= 1'b0; // RULE_11
                state_r <= S_RD;
                cnt_r <= RD_CYC - 1;
              end
            end else begin
              ready <= 1'b1;
              state_r <= S_IDLE;
            end
          end
        end
        S_PD_SETUP: begin
          if (cnt_done) begin
            power_keep_enable <= 1'b0; // RULE_01
            powered_down <= 1'b1;
            state_r <= S_PD_HOLD;
            cnt_r <= C2LP_CYC - 1; // RULE_01
          end
        end
        S_PD_HOLD: begin
          // Exit only after the least low time; chip select is already high
          if (cnt_done && (auto_pd_r || !pd_req)) begin
            power_keep_enable <= 1'b1; // RULE_01
            powered_down <= 1'b0;
            auto_pd_r <= 1'b0;
            state_r <= S_CHH;
            cnt_r <= CHH_CYC - 1; // RULE_02
          end
        end
        default: begin
          chip_select_n <= 1'b1;
          state_r <= S_IDLE;
        end
      endcase
    end
  end

endmodule

/* logic/psram_host_defs.vh */
// Timing and encoding constants for the pseudo-static memory host controller.
// Assumes a single 100 MHz clock; all pin durations become whole cycles.
`ifndef PSRAM_HOST_DEFS_VH
`define PSRAM_HOST_DEFS_VH

// Clock rate and bus widths
`define CLK_MHZ 100
`define ADDR_W 20
`define DATA_W 16
`define PAGE_BITS 3

// Power-down timing
`define T_CSP_NS 10
`define T_C2LP_FAST_NS 80
`define T_C2LP_SLOW_NS 90
`define T_CHH_US 350

// Standby entry settling after chip select rises
`define T_CHX_NS 10

// Power-up timing
`define T_C2LH_US 50
`define T_C2HL_US 50
`define T_CHHP_US 400

// Write cycle timing per grade
`define T_WC_FAST_NS 80
`define T_WC_SLOW_NS 90
`define T_CW_FAST_NS 45
`define T_CW_SLOW_NS 50

// Least times round up to whole cycles; microseconds are exact at this rate
`define CYC_NS(t) ((((t) * `CLK_MHZ) + 999) / 1000)
`define CYC_US(t) ((t) * `CLK_MHZ)

// Power-up sequence choice
`define PU_SEQ_LOW_FIRST 2'h1
`define PU_SEQ_PD_CYCLE 2'h2
`define PU_SEQ_RISE_WITH_SUPPLY 2'h3

// Lane select default when no lane is asked for
`define LANES_BOTH 2'h3
`define LANES_NONE 2'h0

`endif

/* sim/psram_host_props.sv */
// Pin checker for the memory host controller.
// Sees only the controller ports; bound from the bench top.
`include "psram_host_defs.vh"
module psram_host_props #(
  parameter PU_SEQ = `PU_SEQ_LOW_FIRST,
  parameter FAST_GRADE = 0,
  parameter C2LH_CYC = 20,
  parameter CHH_CYC = 40
) (
  // Clock, reset, status
  input wire clk,
  input wire reset,
  input wire init_done,
  // Memory pins
  input wire chip_select_n,
  input wire power_keep_enable,
  input wire write_strobe_n,
  input wire output_strobe_n,
  input wire lower_lane_select_n,
  input wire upper_lane_select_n,
  input wire [`ADDR_W-1:0] mem_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LOW_MIN = FAST_GRADE ? `CYC_NS(`T_C2LP_FAST_NS) : `CYC_NS(`T_C2LP_SLOW_NS);
  // Only sequence one has a long first low; sequence two starts with a plain power-down
  localparam bit LONG_FIRST_LOW = (PU_SEQ == `PU_SEQ_LOW_FIRST);
  logic [15:0] lo_r;
  logic [15:0] hi_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  ////////////////////
  // Enable run lengths, saturated so a long idle never wraps
  always @(posedge clk) begin
    if (reset || power_keep_enable) lo_r <= 16'h0000;
    else if (!(&lo_r)) lo_r <= lo_r + 16'h0001;
    if (reset || !power_keep_enable) hi_r <= 16'h0000;
    else if (!(&hi_r)) hi_r <= hi_r + 16'h0001;
  end
  ////////////////////
  // Open read: chip select and output strobe both low
  sequence s_open_read;
    !chip_select_n && !output_strobe_n;
  endsequence
  property p_pd_low;
    $rose(power_keep_enable) && (init_done || !LONG_FIRST_LOW) |-> lo_r >= LOW_MIN;
  endproperty
  a_pd_low: assert property (p_pd_low) else $error("short power-down");
  property p_pu_low;
    $rose(power_keep_enable) && !init_done && LONG_FIRST_LOW |-> lo_r >= C2LH_CYC;
  endproperty
  a_pu_low: assert property (p_pu_low) else $error("short power-up low");
  property p_cs_hold;
    $fell(chip_select_n) |-> hi_r >= CHH_CYC;
  endproperty
  a_cs_hold: assert property (p_cs_hold) else $error("early access");
  property p_we_settle;
    $rose(chip_select_n) |=> $stable(write_strobe_n);
  endproperty
  a_we_settle: assert property (p_we_settle) else $error("strobe moved");
  property p_read_ctl;
    s_open_read |-> write_strobe_n && power_keep_enable;
  endproperty
  a_read_ctl: assert property (p_read_ctl) else $error("bad read pins");
  property p_lane;
    s_open_read |-> !(lower_lane_select_n && upper_lane_select_n);
  endproperty
  a_lane: assert property (p_lane) else $error("no lane");
  property p_wr_keep;
    !write_strobe_n |-> power_keep_enable;
  endproperty
  a_wr_keep: assert property (p_wr_keep) else $error("write in power-down");
  property p_page;
    s_open_read ##1 s_open_read |-> $stable(mem_addr[`ADDR_W-1:`PAGE_BITS]);
  endproperty
  a_page: assert property (p_page) else $error("page left");
endmodule

/* sim/psram_model.sv */
// Behavioural memory behind the host controller pins.
// Assumes pins change only on clk edges, so it samples them on clk.
`include "psram_host_defs.vh"
module psram_model (
  // Clock
  input wire clk,
  // Memory pins
  input wire chip_select_n,
  input wire power_keep_enable,
  input wire write_strobe_n,
  input wire output_strobe_n,
  input wire lower_lane_select_n,
  input wire upper_lane_select_n,
  input wire [`ADDR_W-1:0] mem_addr,
  input wire [`DATA_W-1:0] dq_out,
  output logic [`DATA_W-1:0] dq_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [`DATA_W-1:0] mem [0:1023];
  wire [9:0] a = mem_addr[9:0];
  wire sel = !chip_select_n && power_keep_enable;
  logic cs_d = 1'b1;
  initial dq_in = 16'h0000;
  ////////////////////
  // A write strobe still low just after chip select rises spoils the word,
  // so a host that skips the standby settling shows up as bad read data
  always @(posedge clk) begin
    cs_d <= chip_select_n;
    if (chip_select_n && !cs_d && !write_strobe_n) mem[a] <= ~dq_out;
  end
  ////////////////////
  // Lane writes; a released bus toggles so stale data never looks valid
  always @(posedge clk) begin
    if (sel && !write_strobe_n && !lower_lane_select_n) mem[a][7:0] <= dq_out[7:0];
    if (sel && !write_strobe_n && !upper_lane_select_n) mem[a][15:8] <= dq_out[15:8];
    if (sel && !output_strobe_n && write_strobe_n) dq_in <= mem[a];
    else dq_in <= ~dq_in;
  end
endmodule

/* sim/testbench.sv */
// Self-checking bench: controller, memory model and pin checker.
// Assumes the slow grade, power-up sequence one and short long counts.
`include "psram_host_defs.vh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; $display("Error t=%0t got %h exp %h", $time, a, b); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int C2LH = 20;
  localparam int CHH = 40;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic req = 1'b0;
  logic req_write = 1'b0;
  logic pd_req = 1'b0;
  logic [1:0] req_lanes = 2'h3;
  logic [`ADDR_W-1:0] req_addr = 20'h00000;
  logic [`DATA_W-1:0] req_wdata = 16'h0000;
  int num_errors = 0;
  int tests_run = 0;
  wire ready, rdata_valid, init_done, powered_down, chip_select_n, power_keep_enable;
  wire write_strobe_n, output_strobe_n, lower_lane_select_n, upper_lane_select_n, dq_oe;
  wire [`ADDR_W-1:0] mem_addr;
  wire [`DATA_W-1:0] rdata, dq_in, dq_out;
  ////////////////////
  // Controller with the long counts cut short
  psram_host #(.C2LH_CYC(C2LH), .C2HL_CYC(20), .CHHP_CYC(30), .CHH_CYC(CHH)) i_dut (
    .clk(clk), .reset(reset), .req(req), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_lanes(req_lanes), .pd_req(pd_req), .ready(ready),
    .rdata(rdata), .rdata_valid(rdata_valid), .init_done(init_done),
    .powered_down(powered_down), .chip_select_n(chip_select_n),
    .power_keep_enable(power_keep_enable), .write_strobe_n(write_strobe_n),
    .output_strobe_n(output_strobe_n), .lower_lane_select_n(lower_lane_select_n),
    .upper_lane_select_n(upper_lane_select_n), .mem_addr(mem_addr), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe(dq_oe));
  // Memory on the far side of the pins
  psram_model i_mem (
    .clk(clk), .chip_select_n(chip_select_n), .power_keep_enable(power_keep_enable),
    .write_strobe_n(write_strobe_n), .output_strobe_n(output_strobe_n),
    .lower_lane_select_n(lower_lane_select_n), .upper_lane_select_n(upper_lane_select_n),
    .mem_addr(mem_addr), .dq_out(dq_out), .dq_in(dq_in));
  initial forever #5 clk = ~clk;
  ////////////////////
  // Verdict and end of run
  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Settled sample point after an edge; bounded waits end the run
  task automatic step;
    @(posedge clk);
    #1;
  endtask
  task automatic bail(input int c);
    if (c > 3000) begin
      num_errors++;
      finish_test();
    end
  endtask
  // One request, held through the edge that takes it
  task automatic issue(input logic w, input logic [19:0] a, input logic [15:0] wd,
                       input logic [1:0] ln);
    int c;
    c = 0;
    while (ready !== 1'b1) begin step(); c++; bail(c); end
    @(posedge clk);
    req <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= wd;
    req_lanes <= ln;
    @(posedge clk);
    req <= 1'b0;
    #1;
  endtask
  // Read one word; a zero latency skips the timing check
  task automatic rd(input logic [19:0] a, input int lat, input logic [15:0] exp);
    int c;
    issue(1'b0, a, 16'h0000, 2'h3);
    c = 0;
    while (rdata_valid !== 1'b1) begin step(); c++; bail(c); end
    if (lat > 0) `CHK(c, lat)
    `CHK(rdata, exp)
    `CHK(mem_addr, a)
    `CHK({output_strobe_n, write_strobe_n}, 2'h1)
  endtask
  ////////////////////
  // Sequence one: enable low first, then chip select held high
  task automatic t_powerup;
    int c;
    c = 0;
    while (power_keep_enable !== 1'b1) begin step(); c++; bail(c); end
    `CHK(c >= C2LH, 1'b1)
    c = 0;
    while (ready !== 1'b1) begin step(); c++; bail(c); end
    `CHK(c >= CHH, 1'b1)
    `CHK(init_done, 1'b1)
    $display("power-up test done");
  endtask
  // Byte lanes, empty mask, page hit, then a read off the page
  task automatic t_rw;
    issue(1'b1, 20'h00010, 16'h1234, 2'h3);
    `CHK({write_strobe_n, dq_oe, power_keep_enable}, 3'h3)
    issue(1'b1, 20'h00010, 16'hABCD, 2'h1);
    `CHK({upper_lane_select_n, lower_lane_select_n}, 2'h2)
    `CHK(dq_out, 16'hABCD)
    issue(1'b1, 20'h00011, 16'hBEEF, 2'h0);
    issue(1'b1, 20'h00021, 16'h5A5A, 2'h3);
    issue(1'b1, 20'h00021, 16'h0F0F, 2'h2);
    rd(20'h00010, 8, 16'h12CD);
    rd(20'h00011, 3, 16'hBEEF);
    // Off-page read waits out recovery, then runs a full read
    rd(20'h00021, 12, 16'h0F5A);
    $display("read-write test done");
  endtask
  // Shortest power-down request, then the exit hold before access
  task automatic t_pd;
    int c;
    @(posedge clk);
    pd_req <= 1'b1;
    c = 0;
    while (powered_down !== 1'b1) begin step(); c++; bail(c); end
    @(posedge clk);
    pd_req <= 1'b0;
    #1;
    c = 1;
    while (power_keep_enable !== 1'b1) begin step(); c++; bail(c); end
    `CHK(c >= 9, 1'b1)
    `CHK(powered_down, 1'b0)
    c = 0;
    while (ready !== 1'b1) begin step(); c++; bail(c); end
    `CHK(c >= CHH, 1'b1)
    rd(20'h00010, 8, 16'h12CD);
    $display("power-down test done");
  endtask
  ////////////////////
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    #1;
    `CHK(chip_select_n, 1'b1)
    `CHK(power_keep_enable, 1'b0)
    @(posedge clk);
    reset <= 1'b0;
    #1;
    t_powerup();
    t_rw();
    t_pd();
    finish_test();
  end
endmodule
bind psram_host psram_host_props #(
  .PU_SEQ(PU_SEQ), .FAST_GRADE(FAST_GRADE), .C2LH_CYC(C2LH_CYC), .CHH_CYC(CHH_CYC)) i_props (
  .clk(clk), .reset(reset), .init_done(init_done), .chip_select_n(chip_select_n),
  .power_keep_enable(power_keep_enable), .write_strobe_n(write_strobe_n),
  .output_strobe_n(output_strobe_n), .lower_lane_select_n(lower_lane_select_n),
  .upper_lane_select_n(upper_lane_select_n), .mem_addr(mem_addr));
